//--- sei_bus_if.sv
/*
 * sei_bus_if: the two-wire link between master and slave memory.
 * Assumes both open-drain lines are pulled up; the wire levels are resolved here.
 */
`timescale 1ns/1ps
`default_nettype none
interface sei_bus_if;
	logic sclOut;
	logic sclOe;
	logic sdaMasterOut;
	logic sdaMasterOe;
	logic sdaSlaveOut;
	logic sdaSlaveOe;
	logic sclLine;
	logic sdaLine;
	// pull-up wins unless an enabled driver pulls low
	assign sclLine = !(sclOe && !sclOut);
	assign sdaLine = !((sdaMasterOe && !sdaMasterOut) || (sdaSlaveOe && !sdaSlaveOut));
	modport master (output sclOut, output sclOe, output sdaMasterOut, output sdaMasterOe,
		input sclLine, input sdaLine);
	modport slave (output sdaSlaveOut, output sdaSlaveOe, input sclLine, input sdaLine);
endinterface : sei_bus_if
`default_nettype wire

//--- sei_bus_master.sv
/*
 * sei_bus_master: master end; byte write, and current-address read of N bytes.
 * Assumes a slave on the interface; clock made by a divider of core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module sei_bus_master (
	input wire logic core_clk,
	input wire logic resetn,
	sei_bus_if.master bus,
	input wire logic cmdValid,
	input wire logic cmdRead,
	input wire logic [7:0] cmdDevice,
	input wire logic [7:0] cmdAddr,
	input wire logic [7:0] cmdData,
	input wire logic [3:0] cmdCount,
	output logic cmdReady,
	output logic rdValid,
	output logic [7:0] rdData,
	output logic nackSeen
);
	typedef enum logic [5:0] {
		MS_IDLE = 6'b00_0001,
		MS_START = 6'b00_0010,
		MS_BIT = 6'b00_0100,
		MS_STOP = 6'b00_1000,
		MS_FREE = 6'b01_0000,
		MS_DONE = 6'b10_0000
	} sei_master_state_type;
	sei_master_state_type state_q;
	logic [7:0] tick_q, txByte_q, rxByte_q;
	logic [1:0] phase_q;
	logic [3:0] bitIdx_q, left_q;
	logic [1:0] byteNo_q;
	logic read_q, sclDrv_q, sdaDrv_q;
	logic [1:0] sdaSync_q;
	logic [7:0] addr_q, data_q;
	wire tickDone = tick_q == 8'(sei_pkg::MASTER_HALF_PERIOD / 2);
	wire isAck = bitIdx_q == 4'd8;
	wire lastByte = read_q ? (byteNo_q != 2'd0 && left_q == 4'd1)
		: byteNo_q == 2'd2;
	assign bus.sclOut = 1'b0;
	assign bus.sclOe = sclDrv_q;
	assign bus.sdaMasterOut = 1'b0;
	assign bus.sdaMasterOe = sdaDrv_q;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sdaSync_q <= 2'b11;
		end else begin
			sdaSync_q <= {sdaSync_q[0], bus.sdaLine};
		end
	end
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_q <= MS_IDLE;
			tick_q <= 8'd0;
			phase_q <= 2'd0;
			bitIdx_q <= 4'd0;
			byteNo_q <= 2'd0;
			left_q <= 4'd0;
			read_q <= 1'b0;
			sclDrv_q <= 1'b0;
			sdaDrv_q <= 1'b0;
			txByte_q <= 8'h00;
			rxByte_q <= 8'h00;
			addr_q <= 8'h00;
			data_q <= 8'h00;
			cmdReady <= 1'b0;
			rdValid <= 1'b0;
			rdData <= 8'h00;
			nackSeen <= 1'b0;
		end else begin
			rdValid <= 1'b0;
			tick_q <= tickDone ? 8'd0 : tick_q + 8'd1;
			case (state_q)
				MS_IDLE: begin
					cmdReady <= 1'b1;
					if (cmdValid && cmdReady) begin
						cmdReady <= 1'b0;
						read_q <= cmdRead;
						txByte_q <= {cmdDevice[7:1], cmdRead};
						addr_q <= cmdAddr;
						data_q <= cmdData;
						left_q <= cmdCount;
						nackSeen <= 1'b0;
						byteNo_q <= 2'd0;
						phase_q <= 2'd0;
						state_q <= MS_START;
					end
				end
				MS_START: if (tickDone) begin
					phase_q <= phase_q + 2'd1;
					if (phase_q == 2'd0) begin
						sdaDrv_q <= 1'b1;
					end else if (phase_q == 2'd1) begin
						sclDrv_q <= 1'b1;
						bitIdx_q <= 4'd0;
						phase_q <= 2'd0;
						state_q <= MS_BIT;
					end
				end
				MS_BIT: if (tickDone) begin
					phase_q <= phase_q + 2'd1;
					case (phase_q)
						// data set up mid low phase
						2'd0: begin
							if (isAck) begin
								sdaDrv_q <= read_q && byteNo_q != 2'd0 && !lastByte;
							end else begin
								sdaDrv_q <= (read_q && byteNo_q != 2'd0) ? 1'b0
									: !txByte_q[3'd7 - bitIdx_q[2:0]];
							end
						end
						2'd1: sclDrv_q <= 1'b0;
						2'd2: begin
							// the ack bit must not push the data msb out
							if (!isAck) begin
								rxByte_q <= {rxByte_q[6:0], sdaSync_q[1]};
							end
							if (isAck && !(read_q && byteNo_q != 2'd0) && sdaSync_q[1]) begin
								nackSeen <= 1'b1;
							end
						end
						default: begin
							sclDrv_q <= 1'b1;
							phase_q <= 2'd0;
							bitIdx_q <= bitIdx_q + 4'd1;
							if (isAck) begin
								bitIdx_q <= 4'd0;
								if (read_q && byteNo_q != 2'd0) begin
									rdValid <= 1'b1;
									rdData <= rxByte_q;
									left_q <= left_q - 4'd1;
								end
								if (lastByte || nackSeen) begin
									state_q <= MS_STOP;
								end else begin
									byteNo_q <= (byteNo_q == 2'd3) ? 2'd3 : byteNo_q + 2'd1;
									txByte_q <= (byteNo_q == 2'd0) ? addr_q : data_q;
								end
							end
						end
					endcase
				end
				MS_STOP: if (tickDone) begin
					phase_q <= phase_q + 2'd1;
					if (phase_q == 2'd0) begin
						sdaDrv_q <= 1'b1;
					end else if (phase_q == 2'd1) begin
						sclDrv_q <= 1'b0;
					end else begin
						sdaDrv_q <= 1'b0;
						phase_q <= 2'd0;
						state_q <= MS_FREE;
					end
				end
				MS_FREE: if (tickDone) begin
					phase_q <= phase_q + 2'd1;
					if (phase_q == 2'd3) begin
						state_q <= MS_DONE;
					end
				end
				default: state_q <= MS_IDLE;
			endcase
		end
	end
endmodule : sei_bus_master
`default_nettype wire

//--- sei_eeprom_slave.sv
/*
 * sei_eeprom_slave: serial memory slave end; address match, byte write, reads,
 * self-timed write cycle, upper-half write protection.
 * Assumes a master that owns the clock line and all start/stop conditions.
 */
`timescale 1ns/1ps
`default_nettype none
module sei_eeprom_slave #(
	parameter bit IS_4KB = 1'b1,
	parameter int WRITE_CYCLES = sei_pkg::WRITE_CYCLES,
	parameter int POWER_UP_CYCLES = sei_pkg::POWER_UP_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	sei_bus_if.slave bus,
	input wire logic select_pin_low,
	input wire logic select_pin_mid,
	input wire logic select_pin_high,
	input wire logic writeProtect,
	output logic busy,
	output logic ready
);
	typedef enum logic [6:0] {
		ST_IDLE = 7'b000_0001,
		ST_DEV = 7'b000_0010,
		ST_ADDR = 7'b000_0100,
		ST_WDATA = 7'b000_1000,
		ST_RDATA = 7'b001_0000,
		ST_IGNORE = 7'b010_0000,
		ST_WAIT = 7'b100_0000
	} sei_slave_state_type;
	sei_slave_state_type state_q, state_d;
	// two flops before any logic looks at the pins
	logic [1:0] sclSync_q, sdaSync_q, pinSync_q [4];
	logic sclF_q, sdaF_q, sclPrev_q, sdaPrev_q;
	logic [3:0] sclCnt_q, sdaCnt_q;
	logic [7:0] shift_q;
	logic [3:0] bitCnt_q;
	logic ackPhase_q, driveLow_q, rwRead_q, protHit_q, wrPending_q, protArm_q;
	logic [sei_pkg::ADDR_WIDTH-1:0] ptr_q, wrAddr_q;
	logic [7:0] wrData_q;
	logic [22:0] busyCnt_q, puCnt_q;
	logic [7:0] mem [sei_pkg::MEM_DEPTH];
	wire sclRise = sclF_q && !sclPrev_q;
	wire sclFall = !sclF_q && sclPrev_q;
	wire startSeen = sclF_q && sclPrev_q && sdaPrev_q && !sdaF_q;
	wire stopSeen = sclF_q && sclPrev_q && !sdaPrev_q && sdaF_q;
	wire [7:0] rxByte = {shift_q[6:0], sdaF_q};
	wire selLow = IS_4KB ? rxByte[1] : pinSync_q[3][1];
	wire devMatch = rxByte[7:4] == sei_pkg::DEVICE_TYPE &&
		rxByte[3:1] == {pinSync_q[2][1], pinSync_q[1][1], selLow};
	wire byteDone = sclRise && !ackPhase_q && bitCnt_q == 4'd7;
	wire upperHalf = IS_4KB ? ptr_q[8] : ptr_q[7];
	wire [7:0] rdByte = mem[ptr_q];
	wire ackRise = sclRise && ackPhase_q;
	// pins: both lines, protect and select inputs
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sclSync_q <= 2'b11;
			sdaSync_q <= 2'b11;
			for (int i = 0; i < 4; i++) begin
				pinSync_q[i] <= 2'b00;
			end
		end else begin
			sclSync_q <= {sclSync_q[0], bus.sclLine};
			sdaSync_q <= {sdaSync_q[0], bus.sdaLine};
			pinSync_q[0] <= {pinSync_q[0][0], writeProtect};
			pinSync_q[1] <= {pinSync_q[1][0], select_pin_mid};
			pinSync_q[2] <= {pinSync_q[2][0], select_pin_high};
			pinSync_q[3] <= {pinSync_q[3][0], select_pin_low};
		end
	end
	// a level must persist past the glitch width before it is believed
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sclF_q <= 1'b1;
			sdaF_q <= 1'b1;
			sclCnt_q <= 4'd0;
			sdaCnt_q <= 4'd0;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclPrev_q <= sclF_q;
			sdaPrev_q <= sdaF_q;
			if (sclSync_q[1] == sclF_q) begin
				sclCnt_q <= 4'd0;
			end else if (sclCnt_q == 4'(sei_pkg::FILTER_CYCLES)) begin
				sclF_q <= sclSync_q[1];
				sclCnt_q <= 4'd0;
			end else begin
				sclCnt_q <= sclCnt_q + 4'd1;
			end
			if (sdaSync_q[1] == sdaF_q) begin
				sdaCnt_q <= 4'd0;
			end else if (sdaCnt_q == 4'(sei_pkg::FILTER_CYCLES)) begin
				sdaF_q <= sdaSync_q[1];
				sdaCnt_q <= 4'd0;
			end else begin
				sdaCnt_q <= sdaCnt_q + 4'd1;
			end
		end
	end
	always_comb begin
		state_d = state_q;
		if (!ready || busy) begin
			state_d = ST_IDLE;
		end else if (startSeen) begin
			state_d = ST_DEV;
		end else if (stopSeen) begin
			state_d = ST_IDLE;
		end else begin
			case (state_q)
				ST_DEV: begin
					if (byteDone) begin
						state_d = devMatch ? ST_WAIT : ST_IGNORE;
					end
				end
				ST_WAIT: begin
					if (ackRise) begin
						state_d = rwRead_q ? ST_RDATA : ST_ADDR;
					end
				end
				ST_ADDR: begin
					if (ackRise) begin
						state_d = ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (ackRise && sdaF_q) begin
						state_d = ST_IGNORE;
					end
				end
				ST_WDATA: begin
					if (ackRise && protHit_q) begin
						state_d = ST_IGNORE;
					end
				end
				default: state_d = state_q;
			endcase
		end
	end
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			shift_q <= 8'h00;
			bitCnt_q <= 4'd0;
			ackPhase_q <= 1'b0;
			driveLow_q <= 1'b0;
			rwRead_q <= 1'b0;
			protHit_q <= 1'b0;
			wrPending_q <= 1'b0;
			ptr_q <= '0;
			wrAddr_q <= '0;
			wrData_q <= 8'h00;
			busyCnt_q <= 23'd0;
			busy <= 1'b0;
			protArm_q <= 1'b0;
			puCnt_q <= 23'(POWER_UP_CYCLES);
			ready <= 1'b0;
		end else begin
			state_q <= state_d;
			if (puCnt_q != 23'd0) begin
				puCnt_q <= puCnt_q - 23'd1;
			end
			ready <= puCnt_q == 23'd0;
			if (busy) begin
				busyCnt_q <= busyCnt_q - 23'd1;
				busy <= busyCnt_q != 23'd1;
				if (busyCnt_q == 23'd1 && wrPending_q) begin
					mem[wrAddr_q] <= wrData_q;
					wrPending_q <= 1'b0;
				end
			end else if (stopSeen && wrPending_q) begin
				busyCnt_q <= 23'(WRITE_CYCLES);
				busy <= 1'b1;
			end
			if (startSeen || state_d == ST_IDLE || state_d == ST_IGNORE) begin
				bitCnt_q <= 4'd0;
				ackPhase_q <= 1'b0;
				driveLow_q <= 1'b0;
				protArm_q <= 1'b0;
				if (startSeen && !busy) begin
					wrPending_q <= 1'b0;
				end
			end else begin
				if (sclRise && !ackPhase_q) begin
					shift_q <= rxByte;
					bitCnt_q <= bitCnt_q + 4'd1;
				end
				if (byteDone) begin
					ackPhase_q <= 1'b1;
					case (state_q)
						ST_DEV: begin
							rwRead_q <= rxByte[0];
							if (IS_4KB) begin
								ptr_q[8] <= rxByte[1];
							end
						end
						ST_ADDR: ptr_q[7:0] <= rxByte;
						ST_WDATA: begin
							wrData_q <= rxByte;
							wrAddr_q <= ptr_q;
							wrPending_q <= !protHit_q;
						end
						default: ;
					endcase
				end
				if (ackRise) begin
					ackPhase_q <= 1'b0;
					bitCnt_q <= 4'd0;
					protArm_q <= state_q == ST_ADDR;
					if (state_q == ST_RDATA) begin
						ptr_q <= ptr_q + 1'b1;
					end
				end
				// outputs move only after a falling edge
				if (sclFall) begin
					if (ackPhase_q && state_q != ST_RDATA) begin
						driveLow_q <= !(state_q == ST_WDATA && protHit_q);
					end else if (state_q == ST_RDATA && !ackPhase_q && bitCnt_q != 4'd8) begin
						driveLow_q <= !rdByte[3'd7 - bitCnt_q[2:0]];
					end else if (state_q == ST_WAIT && ackPhase_q == 1'b0 && rwRead_q) begin
						driveLow_q <= !rdByte[7];
					end else begin
						driveLow_q <= 1'b0;
					end
					// last fall before the data byte, i.e. the end of the address ack
					if (protArm_q) begin
						protHit_q <= pinSync_q[0][1] && upperHalf;
						protArm_q <= 1'b0;
					end
				end
			end
		end
	end
	// open drain: never drive high
	assign bus.sdaSlaveOut = 1'b0;
	assign bus.sdaSlaveOe = driveLow_q;
endmodule : sei_eeprom_slave
`default_nettype wire

//--- sei_eeprom_sva.sv
/*
 * sei_eeprom_sva: link-side checks on the slave memory end.
 * Assumes interface signals and slave status on one core clock, sync active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module sei_eeprom_sva #(
	parameter int WRITE_CYCLES = 200,
	parameter int POWER_UP_CYCLES = 50
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic sclLine,
	input wire logic sdaLine,
	input wire logic sdaSlaveOut,
	input wire logic sdaSlaveOe,
	input wire logic busy,
	input wire logic ready
);
	logic sclPrev_q;
	logic sdaPrev_q;
	logic active_q;
	logic [7:0] sinceStop_q;
	int busyLen_q;
	int upCnt_q;
	// raw lines: the slave filters, so it can only lag these
	wire startSeen = sclPrev_q && sclLine && sdaPrev_q && !sdaLine;
	wire stopSeen = sclPrev_q && sclLine && !sdaPrev_q && sdaLine;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sclPrev_q <= 1'h1;
			sdaPrev_q <= 1'h1;
			active_q <= 1'h0;
			sinceStop_q <= 8'hff;
			busyLen_q <= 0;
			upCnt_q <= 0;
		end else begin
			sclPrev_q <= sclLine;
			sdaPrev_q <= sdaLine;
			active_q <= startSeen || (active_q && !stopSeen);
			sinceStop_q <= stopSeen ? 8'h00 : sinceStop_q + {7'h0, sinceStop_q != 8'hff};
			busyLen_q <= busy ? busyLen_q + 1 : 0;
			upCnt_q <= ready ? upCnt_q : upCnt_q + 1;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_slave_open_drain: assert property (sdaSlaveOe |-> !sdaSlaveOut)
		else $error("slave drove data high");
	a_change_scl_low: assert property ($changed(sdaSlaveOe) |-> !sclLine && !$past(sclLine))
		else $error("slave data moved while clock high");
	a_quiet_before_start: assert property (!active_q |-> !sdaSlaveOe)
		else $error("slave drove outside a frame");
	a_busy_released: assert property (busy |-> !sdaSlaveOe)
		else $error("slave drove while busy");
	a_busy_after_stop: assert property ($rose(busy) |-> sinceStop_q <= 8'h0c)
		else $error("busy began without a stop");
	a_write_length: assert property ($fell(busy) |->
		busyLen_q >= WRITE_CYCLES - 2 && busyLen_q <= WRITE_CYCLES + 1)
		else $error("write cycle length off");
	a_quiet_not_ready: assert property (!ready |-> !sdaSlaveOe)
		else $error("slave drove before ready");
	a_ready_late: assert property (!ready |-> upCnt_q <= POWER_UP_CYCLES + 2)
		else $error("ready came too late");
	a_ready_early: assert property ($rose(ready) |-> upCnt_q >= POWER_UP_CYCLES - 2)
		else $error("ready came too early");
	a_ready_holds: assert property (ready |=> ready)
		else $error("ready dropped");
endmodule : sei_eeprom_sva
`default_nettype wire

//--- sei_pkg.sv
/*
 * sei_pkg: shared constants for the two-wire serial memory slave and its master.
 * Assumes both ends run on one 20 MHz core clock; the link clock is sampled.
 */
`default_nettype none
package sei_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int NONVOLATILE_WRITE_TIME_US = 5000;
	localparam int POWER_UP_READY_DELAY_US = 1000;
	localparam int GLITCH_FILTER_WIDTH_NS = 100;
	// longest times round down
	localparam int WRITE_CYCLES = NONVOLATILE_WRITE_TIME_US * (CLK_HZ / 1_000_000);
	localparam int POWER_UP_CYCLES = POWER_UP_READY_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int FILTER_CYCLES_RAW = (GLITCH_FILTER_WIDTH_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int FILTER_CYCLES = (FILTER_CYCLES_RAW < 1) ? 1 : FILTER_CYCLES_RAW;
	localparam logic [3:0] DEVICE_TYPE = 4'hA;
	localparam int ADDR_WIDTH = 9;
	localparam int MEM_DEPTH = 512;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam int MASTER_HALF_PERIOD = 100;
	localparam int MASTER_BUS_FREE = 40;
endpackage : sei_pkg
`default_nettype wire

//--- serial_eeprom_i2c_slave_write_tb.sv
/*
 * serial_eeprom_i2c_slave_write_tb: master and slave joined; writes, reads, refusals.
 * Assumes design files and the checker compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_i2c_slave_write_tb;
	localparam int WR_CYC = 3000;
	localparam int PU_CYC = 3000;
	logic core_clk = 1'h0;
	logic resetn = 1'h0;
	logic mstResetn = 1'h0;
	logic selLow = 1'h0, selMid = 1'h0, selHigh = 1'h0, writeProtect = 1'h0;
	logic busy, ready, cmdReady, rdValid, nackSeen;
	logic cmdValid = 1'h0, cmdRead = 1'h0;
	logic [7:0] cmdDevice = 8'h00, cmdAddr = 8'h00, cmdData = 8'h00, rdData;
	logic [3:0] cmdCount = 4'h1;
	logic [9:0] notes[$];
	logic [8:0] lastHdr = 9'h000, shiftReg = 9'h000;
	logic sclPrev = 1'h1, sdaPrev = 1'h1, inFrame = 1'h0, nackPrev = 1'h0, busyPrev = 1'h0;
	logic [31:0] seed = 32'h22a8_e3b1;
	int bitCnt = 0;
	int err_count = 0;
	int checks_done = 0;
	sei_bus_if bus ();
	sei_eeprom_slave #(.IS_4KB(1'h1), .WRITE_CYCLES(WR_CYC), .POWER_UP_CYCLES(PU_CYC))
		i_sei_eeprom_slave (.core_clk(core_clk), .resetn(resetn), .bus(bus),
		.select_pin_low(selLow), .select_pin_mid(selMid), .select_pin_high(selHigh),
		.writeProtect(writeProtect), .busy(busy), .ready(ready));
	sei_bus_master i_sei_bus_master (.core_clk(core_clk), .resetn(mstResetn), .bus(bus),
		.cmdValid(cmdValid), .cmdRead(cmdRead), .cmdDevice(cmdDevice), .cmdAddr(cmdAddr),
		.cmdData(cmdData), .cmdCount(cmdCount), .cmdReady(cmdReady), .rdValid(rdValid),
		.rdData(rdData), .nackSeen(nackSeen));
	sei_eeprom_sva #(.WRITE_CYCLES(WR_CYC), .POWER_UP_CYCLES(PU_CYC)) i_sei_eeprom_sva (
		.core_clk(core_clk), .resetn(resetn), .sclLine(bus.sclLine), .sdaLine(bus.sdaLine),
		.sdaSlaveOut(bus.sdaSlaveOut), .sdaSlaveOe(bus.sdaSlaveOe), .busy(busy), .ready(ready));
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic end_of_test();
		$display("checks %0d, errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk
	task automatic take(input logic [9:0] seen);
		if (notes.size() == 0)
			chk(seen, 10'h3ff);
		else
			chk(seen, notes.pop_front());
	endtask : take
	// first byte and its answer bit after each start, straight off the wires
	always @(posedge core_clk) begin
		if (sclPrev && bus.sclLine && sdaPrev && !bus.sdaLine) begin
			bitCnt = 0;
			inFrame = 1'h1;
		end else if (!sclPrev && bus.sclLine && inFrame) begin
			shiftReg = {shiftReg[7:0], bus.sdaLine};
			bitCnt++;
			if (bitCnt == 9) begin
				lastHdr = shiftReg;
				inFrame = 1'h0;
			end
		end
		sclPrev = bus.sclLine;
		sdaPrev = bus.sdaLine;
	end
	always @(posedge core_clk) begin
		if (rdValid === 1'h1)
			take({2'h1, rdData});
		if (nackSeen === 1'h1 && nackPrev !== 1'h1)
			take(10'h200);
		if (busy === 1'h1 && busyPrev !== 1'h1)
			take(10'h300);
		nackPrev <= nackSeen;
		busyPrev <= busy;
	end
	task automatic settle(input logic idle);
		int n;
		n = 0;
		while (notes.size() != 0 || (idle && (busy !== 1'h0 || ready !== 1'h1))) begin
			@(negedge core_clk);
			n++;
			if (n > 40000) begin
				err_count++;
				$display("unexpected at %0t: wait ran out", $time);
				end_of_test();
			end
		end
	endtask : settle
	task automatic run(input logic rd, input logic [7:0] dev, input logic [7:0] addr,
		input logic [7:0] data, input logic [3:0] cnt, input logic ackBit);
		int n;
		n = 0;
		// master restarts only on an idle bus
		for (int k = 0; k < 20000 && n < 300; k++) begin
			@(negedge core_clk);
			n = (bus.sclLine === 1'h1 && bus.sdaLine === 1'h1) ? n + 1 : 0;
		end
		void'(rnd());
		selLow = seed[5];
		mstResetn = 1'h0;
		cmdRead = rd;
		cmdDevice = dev;
		cmdAddr = addr;
		cmdData = data;
		cmdCount = cnt;
		repeat (2) @(negedge core_clk);
		mstResetn = 1'h1;
		for (int k = 0; k < 8 && cmdReady !== 1'h1; k++)
			@(negedge core_clk);
		if (n < 300 || cmdReady !== 1'h1) begin
			err_count++;
			$display("unexpected at %0t: bus or master never ready", $time);
			end_of_test();
		end
		cmdValid = 1'h1;
		@(negedge core_clk);
		cmdValid = 1'h0;
		settle(1'h0);
		chk({1'h0, lastHdr}, {1'h0, dev, ackBit});
	endtask : run
	initial begin
		logic [7:0] d[3];
		logic [7:0] bad[3];
		logic [7:0] a;
		logic [7:0] dev;
		logic [3:0] rc;
		repeat (20) @(negedge core_clk);
		resetn = 1'h1;
		void'(rnd());
		selMid = seed[0];
		selHigh = seed[1];
		writeProtect = seed[3];
		dev = {4'hA, seed[1], seed[0], 2'h0};
		a = {seed[15:12], 2'h0, seed[9:8]};
		d[0] = seed[23:16];
		d[1] = seed[31:24];
		void'(rnd());
		d[2] = seed[7:0];
		notes.push_back(10'h200);
		run(1'h0, dev, a, d[0], 4'h1, 1'h1);
		// top byte first so the pointer ends on the base
		for (int i = 2; i >= 0; i--) begin
			settle(1'h1);
			notes.push_back(10'h300);
			run(1'h0, dev, a + i[7:0], d[i], 4'h1, 1'h0);
		end
		notes.push_back(10'h200);
		run(1'h1, dev | 8'h01, 8'h00, 8'h00, 4'h1, 1'h1);
		settle(1'h1);
		rc = 4'(32'd1 + rnd() % 32'd3);
		for (int i = 0; i < 3; i++) begin
			if (i < rc)
				notes.push_back({2'h1, d[i]});
		end
		run(1'h1, dev | 8'h01, 8'h00, 8'h00, rc, 1'h0);
		bad[0] = dev ^ 8'h10;
		bad[1] = dev ^ 8'h08;
		bad[2] = dev ^ 8'h04;
		foreach (bad[i]) begin
			notes.push_back(10'h200);
			run(1'h0, bad[i], a, d[0], 4'h1, 1'h1);
		end
		writeProtect = 1'h0;
		notes.push_back(10'h300);
		run(1'h0, dev | 8'h02, a, d[1], 4'h1, 1'h0);
		settle(1'h1);
		writeProtect = 1'h1;
		notes.push_back(10'h200);
		run(1'h0, dev | 8'h02, a, ~d[1], 4'h1, 1'h0);
		notes.push_back(10'h300);
		run(1'h0, dev, a, d[0], 4'h1, 1'h0);
		settle(1'h1);
		// upper byte must still hold the unprotected write
		notes.push_back({2'h1, d[1]});
		run(1'h1, dev | 8'h03, 8'h00, 8'h00, 4'h1, 1'h0);
		settle(1'h1);
		end_of_test();
	end
endmodule : serial_eeprom_i2c_slave_write_tb
`default_nettype wire
